// file: itw_pkg.sv
// Constants and field layouts of the interval tick and watchdog block
package itw_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ITW_IDX_ICTL   = 8'h8b;
    localparam logic [7:0] ITW_IDX_ICNT   = 8'h8c;
    localparam logic [7:0] ITW_IDX_WCTL   = 8'h8d;
    localparam logic [7:0] ITW_IDX_WCNT   = 8'h8e;
    localparam logic [7:0] ITW_IDX_IRQST  = 8'h90;
    localparam logic [7:0] ITW_IDX_IRQCLR = 8'h91;
    localparam logic [7:0] ITW_IDX_IRQEN  = 8'h92;
    localparam int         ITW_ADR_W      = 10;

    // Reset values
    localparam logic [7:0] ITW_ICTL_RST = 8'h45;
    localparam logic [7:0] ITW_WCTL_RST = 8'h00;
    localparam logic [7:0] ITW_CMP_RST  = 8'hff;

    // Interrupt status bit positions
    localparam int ITW_ST_INTERVAL = 0;
    localparam int ITW_ST_WATCHDOG = 1;
    localparam int ITW_ST_W        = 2;

    // Divider widths for system clock /4096, /1024, /128, /16
    localparam int ITW_PRE_W  = 12;
    localparam int ITW_DIV0_W = 12;
    localparam int ITW_DIV1_W = 10;
    localparam int ITW_DIV2_W = 7;
    localparam int ITW_DIV3_W = 4;
    // Low-speed oscillator divided by 32
    localparam int ITW_LS_W   = 5;
    // Watchdog prescale by 8
    localparam int ITW_WPRE_W = 3;

    // Interval control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       irq_flag;
        logic [2:0] clock_select;
        logic       count_clear;
        logic [2:0] overflow_select;
    } itw_ictl_t;

    // Watchdog control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       enable;
        logic       reset_enable;
        logic       count_clear;
        logic [2:0] unused;
        logic       prescale_select;
        logic       irq_flag;
    } itw_wctl_t;

    // One decoded bus access
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [7:0]           idx;
        logic [7:0]           data;
    } itw_acc_t;

endpackage

// file: itw_top.sv
// Interval tick timer and watchdog with classic Wishbone register access
`timescale 1ns/100ps

// How it works
// - Eight-bit interval counter runs freely on its selected clock, wrapping.
// - Interval timer gives a stabilisation wait after power-on and stop exit.
// - Interval overflow is the watchdog counting time base.
// - Interval flag sets on overflow; cleared by write 0 or acknowledge.
// - Writing 1 to interval clear zeroes the counter; 0 runs freely.
// - Reset-enable 0 means plain interval timer, 1 means CPU watchdog.
// - Watchdog clear zeroes the counter and self-clears one cycle later.
// - Watchdog flags a request when counter equals the compare value.
// - On match: interrupt when reset-enable is 0, CPU reset when 1.
// - Watchdog counter advances only on interval overflow events.
// - Watchdog interval is one or eight overflow periods, per prescale select, times compare value plus one.
// - Prescale select feeds every overflow, or every eighth overflow.
// - One address reads watchdog count, writes compare value; resets to ff.
// - Watchdog flag sets on interrupt; cleared by write 0 or acknowledge.
module itw_top (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         srst,
    // Wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [itw_pkg::ITW_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // Clock source and power events
    input  wire logic                         low_speed_internal_osc,
    input  wire logic                         stop_wake,
    output logic                              clocks_stable,
    // Core interrupt handshake
    input  wire logic                         interval_irq_ack,
    input  wire logic                         watchdog_irq_ack,
    output logic                              interval_irq,
    output logic                              watchdog_irq,
    output logic                              cpu_reset,
    output logic                              irq
);

    itw_pkg::itw_ictl_t ictl;
    itw_pkg::itw_wctl_t wctl;
    itw_pkg::itw_acc_t  acc;
    logic [7:0]         icnt;
    logic [7:0]         wcnt;
    logic [7:0]         wcmp;
    logic [itw_pkg::ITW_PRE_W-1:0]  pre;
    logic [itw_pkg::ITW_LS_W-1:0]   ls_cnt;
    logic [itw_pkg::ITW_WPRE_W-1:0] wpre;
    logic               ls_q1;
    logic               ls_q2;
    logic               ls_q3;
    logic               stab_wait;
    logic [itw_pkg::ITW_ST_W-1:0] irq_st;
    logic [itw_pkg::ITW_ST_W-1:0] irq_en;

    // Ratio of system clock divider taps
    function automatic logic sys_hit(
        input logic [itw_pkg::ITW_PRE_W-1:0] p,
        input logic [1:0]                    sel
    );
        case (sel)
            2'h0:    sys_hit = &p[itw_pkg::ITW_DIV0_W-1:0];
            2'h1:    sys_hit = &p[itw_pkg::ITW_DIV1_W-1:0];
            2'h2:    sys_hit = &p[itw_pkg::ITW_DIV2_W-1:0];
            default: sys_hit = &p[itw_pkg::ITW_DIV3_W-1:0];
        endcase
    endfunction

    // Low bits that must all be set for an overflow
    function automatic logic [7:0] ovf_mask(input logic [2:0] sel);
        ovf_mask = ~(8'hfe << sel);
    endfunction

    // Bus decode
    wire         bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         lane0     = wb_sel_i[0];
    wire [7:0]   req_idx   = wb_adr_i[itw_pkg::ITW_ADR_W-1:2];
    assign acc.wr   = bus_req & wb_we_i & lane0;
    assign acc.rd   = bus_req & ~wb_we_i;
    assign acc.idx  = req_idx;
    assign acc.data = wb_dat_i[7:0];

    wire wr_ictl  = acc.wr && acc.idx == itw_pkg::ITW_IDX_ICTL;
    wire wr_wctl  = acc.wr && acc.idx == itw_pkg::ITW_IDX_WCTL;
    wire wr_wcmp  = acc.wr && acc.idx == itw_pkg::ITW_IDX_WCNT;
    wire wr_clr   = acc.wr && acc.idx == itw_pkg::ITW_IDX_IRQCLR;
    wire wr_en    = acc.wr && acc.idx == itw_pkg::ITW_IDX_IRQEN;
    wire [7:0] wd = acc.data;

    // Interval clock tick generation
    wire ls_edge  = ls_q2 & ~ls_q3;
    wire ls_tick  = ls_edge & (&ls_cnt);
    wire sys_tick = sys_hit(pre, ictl.clock_select[1:0]);
    wire iclk     = ictl.clock_select[2] ? ls_tick : sys_tick;

    wire iclr     = (wr_ictl & wd[3]) | stop_wake;
    wire [7:0] imask = ovf_mask(ictl.overflow_select);
    wire ovf      = iclk & ((icnt & imask) == imask) & ~iclr;

    wire wd_tick  = ovf & (~wctl.prescale_select | (&wpre));
    wire wd_clear = wctl.count_clear;
    wire wd_run   = wctl.enable & ~wd_clear;
    wire wd_match = wd_run & wd_tick & (wcnt == wcmp);
    wire wd_irq_ev = wd_match & ~wctl.reset_enable;
    wire wd_rst_ev = wd_match & wctl.reset_enable;

    // Flag clears; a setting event in the same cycle wins
    wire iflag_clr = interval_irq_ack | (wr_ictl & ~wd[7]);
    wire wflag_clr = watchdog_irq_ack | (wr_wctl & ~wd[0]);

    wire [itw_pkg::ITW_ST_W-1:0] st_ev = {wd_irq_ev, ovf};

    // Read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (acc.idx)
            itw_pkg::ITW_IDX_ICTL:  rd_mux = {ictl.irq_flag,
                                              ictl.clock_select, 1'b0,
                                              ictl.overflow_select};
            itw_pkg::ITW_IDX_ICNT:  rd_mux = icnt;
            itw_pkg::ITW_IDX_WCTL:  rd_mux = {wctl.enable,
                                              wctl.reset_enable,
                                              wctl.count_clear, 3'h0,
                                              wctl.prescale_select,
                                              wctl.irq_flag};
            itw_pkg::ITW_IDX_WCNT:  rd_mux = wcnt;
            itw_pkg::ITW_IDX_IRQST: rd_mux = {6'h00, irq_st};
            itw_pkg::ITW_IDX_IRQEN: rd_mux = {6'h00, irq_en};
            default:                rd_mux = 8'h00;
        endcase
    end

    // Bus answer, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= acc.rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // Low-speed oscillator synchroniser; edge taken after second stage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ls_q1 <= 1'b0;
            ls_q2 <= 1'b0;
            ls_q3 <= 1'b0;
        end else begin
            ls_q1 <= low_speed_internal_osc;
            ls_q2 <= ls_q1;
            ls_q3 <= ls_q2;
        end
    end

    // Prescalers run freely
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pre    <= '0;
            ls_cnt <= '0;
        end else begin
            pre <= pre + 1'b1;
            if (ls_edge)
                ls_cnt <= ls_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst)
            icnt <= 8'h00;
        else if (iclr)
            icnt <= 8'h00;
        else if (iclk)
            icnt <= icnt + 1'b1;
    end

    // stabilisation wait ends at first overflow
    always_ff @(posedge ref_clk) begin
        if (srst)
            stab_wait <= 1'b1;
        else if (stop_wake)
            stab_wait <= 1'b1;
        else if (ovf)
            stab_wait <= 1'b0;
    end
    assign clocks_stable = ~stab_wait;

    // Interval control; clear bit never stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ictl <= itw_pkg::ITW_ICTL_RST;
        end else begin
            if (wr_ictl) begin
                ictl.clock_select    <= wd[6:4];
                ictl.overflow_select <= wd[2:0];
            end
            ictl.count_clear <= 1'b0;
            if (ovf)
                ictl.irq_flag <= 1'b1;
            else if (iflag_clr)
                ictl.irq_flag <= 1'b0;
        end
    end

    // Watchdog control
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wctl <= itw_pkg::ITW_WCTL_RST;
        end else begin
            if (wr_wctl) begin
                wctl.enable          <= wd[7];
                wctl.reset_enable    <= wd[6];
                wctl.prescale_select <= wd[1];
            end
            wctl.count_clear <= wr_wctl & wd[5];
            wctl.unused      <= 3'h0;
            if (wd_irq_ev)
                wctl.irq_flag <= 1'b1;
            else if (wflag_clr)
                wctl.irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst)
            wcmp <= itw_pkg::ITW_CMP_RST;
        else if (wr_wcmp)
            wcmp <= wd;
    end

    always_ff @(posedge ref_clk) begin
        if (srst)
            wpre <= '0;
        else if (wd_clear)
            wpre <= '0;
        else if (ovf & wctl.enable)
            wpre <= wpre + 1'b1;
    end

    // watchdog counter steps on overflow ticks
    // wraps after compare value plus one ticks
    always_ff @(posedge ref_clk) begin
        if (srst)
            wcnt <= 8'h00;
        else if (wd_clear || wd_match)
            wcnt <= 8'h00;
        else if (wd_run & wd_tick)
            wcnt <= wcnt + 1'b1;
    end

    // reset pulse only in watchdog mode
    always_ff @(posedge ref_clk) begin
        if (srst)
            cpu_reset <= 1'b0;
        else
            cpu_reset <= wd_rst_ev;
    end

    // Interrupt status, write-one clear, set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_st <= '0;
            irq_en <= '0;
        end else begin
            irq_st <= st_ev | (irq_st & ~(wr_clr ? wd[1:0] : 2'h0));
            if (wr_en)
                irq_en <= wd[1:0];
        end
    end

    assign irq          = |(irq_st & irq_en);
    assign interval_irq = ictl.irq_flag;
    assign watchdog_irq = wctl.irq_flag;

    // Checks
    sequence wd_clear_write;
        wr_wctl && wd[5];
    endsequence

    sequence wd_clear_done;
        wctl.count_clear ##1 !wctl.count_clear && wcnt == 8'h00;
    endsequence

    interval_step_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        iclk && !iclr |=> icnt == $past(icnt) + 8'h01)
        else $error("interval counter missed a tick");

    stab_wait_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        stop_wake |=> !clocks_stable && icnt == 8'h00)
        else $error("stabilisation wait not restarted");

    iflag_set_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        ovf |=> interval_irq)
        else $error("interval flag not set on overflow");

    icount_clear_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wr_ictl && wd[3] |=> icnt == 8'h00)
        else $error("interval counter not cleared");

    wd_selfclear_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wd_clear_write |=> wd_clear_done)
        else $error("watchdog clear did not self clear");

    wd_base_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wcnt != $past(wcnt) |-> $past(wd_tick) || $past(wd_clear))
        else $error("watchdog counted without overflow");

    wd_reset_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wd_match && wctl.reset_enable |=> cpu_reset && !$past(wd_irq_ev))
        else $error("watchdog reset not issued");

    wd_irq_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wd_match && !wctl.reset_enable |=> watchdog_irq && wcnt == 8'h00)
        else $error("watchdog interrupt not raised on match");

    wd_disabled_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !wctl.enable && !wd_clear |=> $stable(wcnt))
        else $error("disabled watchdog counted");

    wd_prescale_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wd_tick && wctl.prescale_select |-> wpre == 3'h7)
        else $error("watchdog prescale not by eight");

    cmp_load_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wr_wcmp |=> wcmp == $past(wd))
        else $error("compare value not loaded");

    count_read_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        acc.rd && acc.idx == itw_pkg::ITW_IDX_WCNT
        |=> wb_dat_o[7:0] == $past(wcnt))
        else $error("shared address did not return count");

    no_reset_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !wctl.reset_enable |=> !cpu_reset)
        else $error("reset pulse outside watchdog mode");

    iflag_ack_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        interval_irq_ack && !ovf |=> !interval_irq)
        else $error("interval flag not cleared by acknowledge");

endmodule // itw_top

// file: itw_tb.sv
// Self-checking bench for the interval tick timer and watchdog
`timescale 1ns/100ps
module tb;
    logic        ref_clk, srst, cyc, stb, we, lso, wake, iack, wack;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, wb_dat_o;
    logic        wb_ack_o, clocks_stable, interval_irq, watchdog_irq;
    logic        cpu_reset, irq;
    logic [7:0]  r0, r1;
    int          n_fail, comparisons, n, lso_div;

    itw_top u_dut (
        .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .low_speed_internal_osc(lso), .stop_wake(wake),
        .clocks_stable(clocks_stable), .interval_irq_ack(iack),
        .watchdog_irq_ack(wack), .interval_irq(interval_irq),
        .watchdog_irq(watchdog_irq), .cpu_reset(cpu_reset), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Oscillator rises every 8 clocks
    always @(posedge ref_clk) begin
        lso_div <= (lso_div + 1) % 4;
        if (lso_div == 3) lso <= ~lso;
    end

    task tally_and_finish;
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
              output logic [7:0] rd);
        int k;
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
        adr <= {idx, 2'b00}; dat <= {24'h000000, wd};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        check(k < 50, 1'b1);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        xfer(1'b1, idx, d, x);
    endtask

    task rd(input logic [7:0] idx, output logic [7:0] d);
        xfer(1'b0, idx, 8'h00, d);
    endtask

    // Count advance over a span of p clocks between the two taking edges
    task count_span(input logic [7:0] idx, input int p, output logic [7:0] d);
        rd(idx, r0);
        repeat (p - 3) @(posedge ref_clk);
        rd(idx, r1);
        d = r1 - r0;
    endtask

    // Clocks between two watchdog flag sets, flag acknowledged in between
    task wdt_period(output int c);
        // Stale flag from an earlier match would end the first wait early
        wack <= 1'b1;
        @(posedge ref_clk);
        wack <= 1'b0;
        @(posedge ref_clk);
        c = 0;
        while (watchdog_irq !== 1'b1 && c < 3000) begin
            @(posedge ref_clk);
            c++;
        end
        wack <= 1'b1;
        @(posedge ref_clk);
        wack <= 1'b0;
        @(posedge ref_clk);
        c = 2;
        while (watchdog_irq !== 1'b1 && c < 3000) begin
            @(posedge ref_clk);
            c++;
        end
    endtask

    task t_reset_and_power_on;
        logic [7:0] d;
        rd(8'h8b, d); check(d, 8'h45);
        rd(8'h8c, d); check(d, 8'h00);
        rd(8'h8d, d); check(d, 8'h00);
        rd(8'h8e, d); check(d, 8'h00);
        rd(8'h80, d); check(d, 8'h00);
        count_span(8'h8c, 512, d); check(d, 8'h02);
        n = 0;
        while (clocks_stable !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        check(clocks_stable, 1'b1);
        check(interval_irq, 1'b1);
    endtask

    task t_interval;
        logic [7:0] d;
        wr(8'h8b, 8'h38);
        rd(8'h8c, d); check(d < 2, 1'b1);
        count_span(8'h8c, 64, d); check(d, 8'h04);
        wr(8'h8b, 8'h28);
        count_span(8'h8c, 256, d); check(d, 8'h02);
        wr(8'h8b, 8'h18);
        count_span(8'h8c, 2048, d); check(d, 8'h02);
        wr(8'h8b, 8'h08);
        count_span(8'h8c, 8192, d); check(d, 8'h02);
        wr(8'h8b, 8'h30);
        while (interval_irq !== 1'b1) @(posedge ref_clk);
        wr(8'h8b, 8'h30); check(interval_irq, 1'b0);
        wr(8'h8b, 8'hb0); check(interval_irq, 1'b0);
        while (interval_irq !== 1'b1) @(posedge ref_clk);
        iack <= 1'b1;
        @(posedge ref_clk);
        iack <= 1'b0;
        @(posedge ref_clk);
        check(interval_irq, 1'b0);
    endtask

    task t_watchdog;
        logic [7:0] d;
        wr(8'h8e, 8'h02);
        wr(8'h8d, 8'h80);
        wdt_period(n); check(n, 96);
        wr(8'h92, 8'h02);
        @(posedge ref_clk);
        check(irq, 1'b1);
        rd(8'h90, d); check(d[1], 1'b1);
        wr(8'h91, 8'h02);
        check(irq, 1'b0);
        wr(8'h92, 8'h00);
        wdt_period(n); check(n, 96);
        @(posedge ref_clk);
        check(irq, 1'b0);
        wr(8'h92, 8'h02); check(irq, 1'b1);
        wr(8'h8d, 8'h80); check(watchdog_irq, 1'b0);
        wr(8'h8e, 8'h01);
        wr(8'h8d, 8'h82);
        wdt_period(n); check(n, 512);
        wr(8'h8d, 8'ha0);
        rd(8'h8d, d); check(d[7:5], 3'b100);
        rd(8'h8e, d); check(d < 2, 1'b1);
        wr(8'h8d, 8'h00);
        count_span(8'h8e, 100, d); check(d, 8'h00);
    endtask

    task t_reset_mode;
        wr(8'h8d, 8'hc0);
        n = 0;
        while (cpu_reset !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        check(cpu_reset, 1'b1);
        n = 1;
        @(posedge ref_clk);
        check(cpu_reset, 1'b0);
        while (cpu_reset !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        check(n, 64);
        check(watchdog_irq, 1'b0);
        wr(8'h8d, 8'h00);
    endtask

    task t_stop_exit;
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        @(posedge ref_clk);
        check(clocks_stable, 1'b0);
        n = 0;
        while (clocks_stable !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        check(clocks_stable, 1'b1);
    endtask

    // Hang guard sized well beyond the longest wait
    initial begin
        #(40 * 60000);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        n_fail = 0; comparisons = 0; lso_div = 0; lso = 1'b0;
        srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0;
        sel = 4'h0; dat = '0; wake = 1'b0; iack = 1'b0; wack = 1'b0;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset_and_power_on;
        t_interval;
        t_watchdog;
        t_reset_mode;
        t_stop_exit;
        tally_and_finish;
    end
endmodule // tb
